// file: src/rhp_cfg.svh
// Constants of the nibble host port and interrupt block.
// Assumes inclusion by bare name from package and modules.
`ifndef RHP_CFG_SVH
`define RHP_CFG_SVH

// ----------------------------------------------------------------
// Port geometry
// ----------------------------------------------------------------
`define RHP_ADDR_W 4
`define RHP_DATA_W 4
`define RHP_LOCS 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RHP_STORE_RST 64'h0000_0000_0000_0000
`define RHP_NIB_RST 4'h0

// ----------------------------------------------------------------
// Cyclic periods in 32.768 kHz ticks
// ----------------------------------------------------------------
`define RHP_XTAL_HZ 32768
`define RHP_CYC_TICKS_0 21'h00_0010
`define RHP_CYC_TICKS_1 21'h00_0020
`define RHP_CYC_TICKS_2 21'h00_0100
`define RHP_CYC_TICKS_3 21'h00_0800
`define RHP_CYC_TICKS_4 21'h00_8000
`define RHP_CYC_TICKS_5 21'h1E_0000
`define RHP_CYC_CNT_W 21

// Period selector codes
`define RHP_SEL_OFF 3'h0
`define RHP_SEL_488US 3'h1
`define RHP_SEL_977US 3'h2
`define RHP_SEL_7813US 3'h3
`define RHP_SEL_62MS 3'h4
`define RHP_SEL_1S 3'h5
`define RHP_SEL_60S 3'h6

`endif

// file: src/rhp_cyclic.sv
// Cyclic interrupt source counting 32.768 kHz ticks.
// Assumes tick_in is a one-cycle pulse synchronous to clk_in.
`timescale 1ns/1ns
`include "rhp_cfg.svh"

module rhp_cyclic
  import rhp_pkg::*;
#(
  parameter int CNT_W = `RHP_CYC_CNT_W
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic tick_in,
  input wire logic [2:0] period_sel_in,
  input wire logic level_mode_in,
  input wire logic flag_clear_in,
  output logic request_out
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic req;
  } rhp_cyc_state_t;

  rhp_cyc_state_t st;
  rhp_cyc_state_t next_st;

  // ----------------------------------------------------------------
  // Period decode
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] period_of(input logic [2:0] sel);
    case (sel)
      `RHP_SEL_488US: period_of = CNT_W'(`RHP_CYC_TICKS_0);
      `RHP_SEL_977US: period_of = CNT_W'(`RHP_CYC_TICKS_1);
      `RHP_SEL_7813US: period_of = CNT_W'(`RHP_CYC_TICKS_2);
      `RHP_SEL_62MS: period_of = CNT_W'(`RHP_CYC_TICKS_3);
      `RHP_SEL_1S: period_of = CNT_W'(`RHP_CYC_TICKS_4);
      `RHP_SEL_60S: period_of = CNT_W'(`RHP_CYC_TICKS_5);
      default: period_of = '0;
    endcase
  endfunction : period_of

  always_comb begin
    logic [CNT_W-1:0] per;
    logic fire;
    per = period_of(period_sel_in);
    fire = 1'b0;
    next_st = st;
    if (per == '0) begin
      next_st.cnt = '0;
    end else if (tick_in) begin
      if (st.cnt >= per - CNT_W'(1)) begin
        next_st.cnt = '0;
        fire = 1'b1;
      end else begin
        next_st.cnt = st.cnt + CNT_W'(1);
      end
    end
    if (level_mode_in) begin
      if (fire) begin
        next_st.req = 1'b1;
      end else if (flag_clear_in) begin
        next_st.req = 1'b0;
      end
    end else begin
      // Pulse lasts one tick period; clear input ignored here
      if (fire) begin
        next_st.req = 1'b1;
      end else if (tick_in) begin
        next_st.req = 1'b0;
      end
    end
    if (per == '0) begin
      next_st.req = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign request_out = st.req;

endmodule : rhp_cyclic

// file: src/rhp_host_port.sv
// Nibble-wide host port with sixteen locations and the combined
// interrupt output of the real-time clock.
// Assumes host pins already synchronous to clk_in and a one-cycle
// 32.768 kHz tick from the oscillator section.
//
// Function
// - Enable high: strobes combine with select
// - Enable low: strobes ignored, data undriven
// - Read: device drives addressed nibble
// - Write: addressed nibble stored at strobe end
// - Select and strobe order interchangeable
// - Alarm match of minutes, hours pulls irq
// - Cyclic request pulls irq periodically
// - Irq pin is OR of both requests
// - Separate readable alarm and cyclic flags
// - Interrupts run regardless of enable
// - Irq inactive (high) from reset
// - Six cyclic periods selectable
// - Cyclic pulse mode or held level
// - Flags read inverse to irq pin
// - Alarm irq gated by enable and flag
`timescale 1ns/1ns
`include "rhp_cfg.svh"

module rhp_host_port
  import rhp_pkg::*;
#(
  parameter int LOCS = `RHP_LOCS
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Host bus pins
  input wire logic iface_enable_in,
  input wire logic select_n_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic [3:0] nibble_addr_lines_in,
  input wire logic [3:0] nibble_data_lines_in,
  output logic [3:0] nibble_data_lines_out,
  output logic nibble_data_lines_oe_n_out,
  // Timebase and time counter
  input wire logic tick_32k_in,
  input wire logic [7:0] time_minutes_in,
  input wire logic [7:0] time_hours_in,
  input wire logic [7:0] alarm_minutes_in,
  input wire logic [7:0] alarm_hours_in,
  // Interrupt control
  input wire logic alarm_enable_bit_in,
  input wire logic alarm_flag_clear_in,
  input wire logic cyclic_level_mode_bit_in,
  input wire logic [2:0] cyclic_period_sel_in,
  input wire logic cyclic_flag_clear_in,
  output logic alarm_flag_out,
  output logic cyclic_flag_out,
  output logic irq_out_n,
  // Stored nibbles and write notification
  output logic [4*LOCS-1:0] store_out,
  output logic write_done_out,
  output logic [3:0] write_addr_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rhp_acc_t acc;
    logic [3:0] wr_addr;
    logic [3:0] wr_data;
    rhp_drive_t drive;
    logic [4*LOCS-1:0] store;
    logic wr_done;
    logic alarm_flag;
    logic match_d;
  } rhp_state_t;

  rhp_state_t st;
  rhp_state_t next_st;
  rhp_bus_t bus;
  rhp_hm_t now_hm;
  rhp_hm_t alarm_hm;
  logic cyc_req;

  assign bus = '{
    iface_enable: iface_enable_in,
    select_n: select_n_in,
    read_n: read_n_in,
    write_n: write_n_in,
    nibble_addr_lines: nibble_addr_lines_in,
    nibble_data_lines: nibble_data_lines_in
  };
  assign now_hm = '{hours: time_hours_in, minutes: time_minutes_in};
  assign alarm_hm = '{hours: alarm_hours_in, minutes: alarm_minutes_in};

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] nib_at(
    input logic [4*LOCS-1:0] arr,
    input logic [3:0] idx
  );
    nib_at = arr[idx*4 +: 4];
  endfunction : nib_at

  // ----------------------------------------------------------------
  // Cyclic source
  // ----------------------------------------------------------------
  // periodic request
  rhp_cyclic u_cyclic (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .tick_in(tick_32k_in),
    .period_sel_in(cyclic_period_sel_in),
    .level_mode_in(cyclic_level_mode_bit_in),
    .flag_clear_in(cyclic_flag_clear_in),
    .request_out(cyc_req)
  );

  // ----------------------------------------------------------------
  // Access decode and alarm
  // ----------------------------------------------------------------
  always_comb begin
    logic rd_ov;
    logic wr_ov;
    logic match;
    rd_ov = bus.iface_enable && !bus.select_n && !bus.read_n;
    wr_ov = bus.iface_enable && !bus.select_n && !bus.write_n;
    match = (now_hm == alarm_hm);
    next_st = st;
    next_st.wr_done = 1'b0;

    case (st.acc)
      RHP_IDLE: begin
        if (wr_ov) begin
          next_st.acc = RHP_WRITE;
          next_st.wr_addr = bus.nibble_addr_lines;
          next_st.wr_data = bus.nibble_data_lines;
        end else if (rd_ov) begin
          next_st.acc = RHP_READ;
        end
      end
      RHP_READ: begin
        if (!rd_ov) begin
          next_st.acc = RHP_IDLE;
        end
      end
      RHP_WRITE: begin
        if (wr_ov) begin
          // Latest data and address before the rising strobe win
          next_st.wr_addr = bus.nibble_addr_lines;
          next_st.wr_data = bus.nibble_data_lines;
        end else begin
          next_st.acc = RHP_IDLE;
          next_st.store[st.wr_addr*4 +: 4] = st.wr_data;
          next_st.wr_done = 1'b1;
        end
        if (!bus.iface_enable) begin
          next_st.acc = RHP_IDLE;
          next_st.wr_done = 1'b0;
          next_st.store = st.store;
        end
      end
      default: begin
        next_st.acc = RHP_IDLE;
      end
    endcase

    if (rd_ov) begin
      next_st.drive.data = nib_at(next_st.store, bus.nibble_addr_lines);
      next_st.drive.oe_n = 1'b0;
    end else begin
      next_st.drive.data = `RHP_NIB_RST;
      next_st.drive.oe_n = 1'b1;
    end

    // alarm on minutes and hours match
    next_st.match_d = match;
    if (match && !st.match_d && alarm_enable_bit_in) begin
      next_st.alarm_flag = 1'b1;
    end else if (alarm_flag_clear_in || !alarm_enable_bit_in) begin
      next_st.alarm_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st.acc <= RHP_IDLE;
      st.wr_addr <= `RHP_NIB_RST;
      st.wr_data <= `RHP_NIB_RST;
      st.drive.data <= `RHP_NIB_RST;
      st.drive.oe_n <= 1'b1;
      st.store <= `RHP_STORE_RST;
      st.wr_done <= 1'b0;
      st.alarm_flag <= 1'b0;
      st.match_d <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign nibble_data_lines_out = st.drive.data;
  assign nibble_data_lines_oe_n_out = st.drive.oe_n;
  assign alarm_flag_out = st.alarm_flag;
  assign cyclic_flag_out = cyc_req;
  // alarm gated by enable and flag
  assign irq_out_n = !((st.alarm_flag && alarm_enable_bit_in) || cyc_req);
  assign store_out = st.store;
  assign write_done_out = st.wr_done;
  assign write_addr_out = st.wr_addr;

endmodule : rhp_host_port

// file: src/rhp_pkg.sv
// Types shared by the nibble host port and its cyclic source.
// Assumes rhp_cfg.svh is on the include path.
`include "rhp_cfg.svh"

package rhp_pkg;

  // ----------------------------------------------------------------
  // Host bus pins as seen by the device
  // ----------------------------------------------------------------
  typedef struct packed {
    logic iface_enable;
    logic select_n;
    logic read_n;
    logic write_n;
    logic [`RHP_ADDR_W-1:0] nibble_addr_lines;
    logic [`RHP_DATA_W-1:0] nibble_data_lines;
  } rhp_bus_t;

  // Data pin drive towards the host
  typedef struct packed {
    logic [`RHP_DATA_W-1:0] data;
    logic oe_n;
  } rhp_drive_t;

  // Time and alarm comparison words, BCD
  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
  } rhp_hm_t;

  typedef enum logic [1:0] {
    RHP_IDLE,
    RHP_READ,
    RHP_WRITE
  } rhp_acc_t;

endpackage : rhp_pkg

// file: tb/rhp_host_model.sv
// Host CPU bus model driving select, strobes, address and data.
// Assumes the port answers reads within four clock edges.
`timescale 1ns/1ns
module rhp_host_model (
  input wire logic clk_in,
  input wire logic oe_n_in,
  input wire logic [3:0] rdata_in,
  output logic select_n_out = 1'b1,
  output logic read_n_out = 1'b1,
  output logic write_n_out = 1'b1,
  output logic [3:0] addr_out = 4'h0,
  output logic [3:0] data_out = 4'h0
);
  task automatic wr(input logic [3:0] a, input logic [3:0] d,
                    input logic strobe_first);
    @(posedge clk_in);
    addr_out <= a;
    data_out <= d;
    write_n_out <= 1'b0;
    select_n_out <= strobe_first;
    if (strobe_first) begin
      @(posedge clk_in);
      select_n_out <= 1'b0;
    end
    repeat (2) @(posedge clk_in);
    write_n_out <= 1'b1;
    @(posedge clk_in);
    select_n_out <= 1'b1;
    // Released lines show the inverse, not a stale value
    addr_out <= ~a;
    data_out <= ~d;
    repeat (2) @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [3:0] q,
                    output logic ok);
    int n;
    @(posedge clk_in);
    addr_out <= a;
    select_n_out <= 1'b0;
    read_n_out <= 1'b0;
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clk_in);
      #1;
      ok = (oe_n_in === 1'b0);
    end
    q = rdata_in;
    @(posedge clk_in);
    read_n_out <= 1'b1;
    @(posedge clk_in);
    select_n_out <= 1'b1;
    addr_out <= ~a;
  endtask : rd
endmodule : rhp_host_model

// file: tb/rhp_port_assertions.sv
// Concurrent checks on the ports of the nibble host port.
// Assumes one clock domain and registered read and write answers.
`timescale 1ns/1ns
`include "rhp_cfg.svh"
module rhp_port_chk
  import rhp_pkg::*;
#(
  parameter int LOCS = `RHP_LOCS
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic iface_enable_in,
  input wire logic select_n_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic [3:0] nibble_addr_lines_in,
  input wire logic [3:0] nibble_data_lines_in,
  input wire logic [3:0] nibble_data_lines_out,
  input wire logic nibble_data_lines_oe_n_out,
  input wire logic [7:0] time_minutes_in,
  input wire logic [7:0] time_hours_in,
  input wire logic [7:0] alarm_minutes_in,
  input wire logic [7:0] alarm_hours_in,
  input wire logic alarm_enable_bit_in,
  input wire logic alarm_flag_out,
  input wire logic cyclic_flag_out,
  input wire logic irq_out_n,
  input wire logic [4*LOCS-1:0] store_out,
  input wire logic write_done_out,
  input wire logic [3:0] write_addr_out
);
  // ----------------------------------------------------------------
  // Access sequences and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic hm_eq;
  assign hm_eq = {time_hours_in, time_minutes_in} ==
                 {alarm_hours_in, alarm_minutes_in};
  sequence rd_ovl;
    iface_enable_in && !select_n_in && !read_n_in && write_n_in;
  endsequence
  sequence wr_ovl;
    iface_enable_in && !select_n_in && !write_n_in && read_n_in;
  endsequence
  sequence wr_gone;
    iface_enable_in && (select_n_in || write_n_in);
  endsequence
  a_read_drive: assert property (rd_ovl |=> !nibble_data_lines_oe_n_out)
    else $error("read overlap not answered");
  a_read_data: assert property (rd_ovl |=> nibble_data_lines_out ==
      store_out[4*$past(nibble_addr_lines_in)+:4])
    else $error("read data differs from store");
  a_write_commit: assert property (wr_ovl ##1 wr_gone |=> write_done_out
      && write_addr_out == $past(nibble_addr_lines_in, 2)
      && store_out[4*write_addr_out+:4] == $past(nibble_data_lines_in, 2))
    else $error("write not committed");
  a_store_hold: assert property (!write_done_out |-> $stable(store_out))
    else $error("store changed without write");
  a_quiet_off: assert property (!iface_enable_in |=>
      nibble_data_lines_oe_n_out)
    else $error("data driven with port disabled");
  a_off_no_write: assert property (!iface_enable_in [*2] |=>
      !write_done_out)
    else $error("write taken with port disabled");
  a_idle_data_zero: assert property (nibble_data_lines_oe_n_out |->
      nibble_data_lines_out == 4'h0)
    else $error("data nonzero while undriven");
  a_irq_or: assert property (irq_out_n ==
      !((alarm_flag_out && alarm_enable_bit_in) || cyclic_flag_out))
    else $error("irq is not or of flags");
  a_alarm_set: assert property (alarm_enable_bit_in && $rose(hm_eq) |=>
      alarm_flag_out)
    else $error("alarm match not flagged");
  a_alarm_gate: assert property (!alarm_enable_bit_in |=>
      !alarm_flag_out)
    else $error("alarm flag with enable low");
endmodule : rhp_port_chk

bind rhp_host_port rhp_port_chk #(.LOCS(LOCS)) u_chk (.*);

// file: tb/test_rhp_host_port.sv
// Self-checking bench of the nibble host port and interrupt output.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
module test_rhp_host_port
  import rhp_pkg::*;
;
  logic clk_in = 1'b0, arst_n_in = 1'b0, en = 1'b1, tick = 1'b1;
  logic [7:0] tmin = 8'h00, thr = 8'h00, amin = 8'h30, ahr = 8'h12;
  logic aen = 1'b1, aclr = 1'b0, lvl = 1'b0, cclr = 1'b0;
  logic [2:0] psel = 3'h0;
  logic sel_n, rd_n, wr_n, oe_n, aflag, cflag, irq_n, wd, ok;
  logic [3:0] addr, wdat, rdat, waddr, q;
  logic [63:0] store;
  logic [31:0] per [1:5] = '{32'h0000_0010, 32'h0000_0020,
    32'h0000_0100, 32'h0000_0800, 32'h0000_8000};
  int error_cnt = 0, checks_done = 0, n, i;
  // enable always driven, no timer use
  always #5 clk_in = ~clk_in;
  rhp_host_port uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .iface_enable_in(en), .select_n_in(sel_n), .read_n_in(rd_n),
    .write_n_in(wr_n), .nibble_addr_lines_in(addr),
    .nibble_data_lines_in(wdat), .nibble_data_lines_out(rdat),
    .nibble_data_lines_oe_n_out(oe_n), .tick_32k_in(tick),
    .time_minutes_in(tmin), .time_hours_in(thr),
    .alarm_minutes_in(amin), .alarm_hours_in(ahr),
    .alarm_enable_bit_in(aen), .alarm_flag_clear_in(aclr),
    .cyclic_level_mode_bit_in(lvl), .cyclic_period_sel_in(psel),
    .cyclic_flag_clear_in(cclr), .alarm_flag_out(aflag),
    .cyclic_flag_out(cflag), .irq_out_n(irq_n), .store_out(store),
    .write_done_out(wd), .write_addr_out(waddr));
  rhp_host_model host (.clk_in(clk_in), .oe_n_in(oe_n),
    .rdata_in(rdat), .select_n_out(sel_n), .read_n_out(rd_n),
    .write_n_out(wr_n), .addr_out(addr), .data_out(wdat));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // Waits for the next rising edge of the cyclic flag
  task automatic wait_cyc(output int n);
    n = 0;
    for (int k = 0; k < 2; k++) begin
      while (cflag !== (k == 1) && n < 70000) begin
        @(posedge clk_in);
        #1;
        n++;
      end
    end
    if (n >= 70000) begin
      $display("ERROR cyclic wait expected flag seen none");
      error_cnt++;
      end_of_test();
    end
  endtask : wait_cyc
  initial begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("irq_rst", 1'h1, irq_n);
    // ----------------------------------------------------------------
    // Host accesses
    // ----------------------------------------------------------------
    // every location, both orders
    for (i = 0; i < 16; i++) begin
      host.wr(i[3:0], i[3:0] ^ 4'hA, i[0]);
      chk("store", i[3:0] ^ 4'hA, store[4*i+:4]);
    end
    for (i = 0; i < 16; i++) begin
      host.rd(i[3:0], q, ok);
      chk("rd_ok", 1'h1, ok);
      chk("rdata", i[3:0] ^ 4'hA, q);
    end
    @(posedge clk_in);
    en <= 1'b0;
    host.wr(4'h3, 4'h0, 1'b0);
    chk("store_off", 4'h9, store[15:12]);
    host.rd(4'h3, q, ok);
    chk("rd_off", 1'h0, ok);
    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // alarm with port disabled
    @(posedge clk_in);
    tmin <= 8'h30;
    thr <= 8'h12;
    repeat (2) @(posedge clk_in);
    #1;
    chk("alarm", 1'h1, aflag);
    chk("irq_alarm", 1'h0, irq_n);
    @(posedge clk_in);
    aclr <= 1'b1;
    @(posedge clk_in);
    aclr <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk("alarm_clr", 1'h0, aflag);
    chk("irq_idle", 1'h1, irq_n);
    @(posedge clk_in);
    aen <= 1'b0;
    tmin <= 8'h00;
    @(posedge clk_in);
    tmin <= 8'h30;
    repeat (2) @(posedge clk_in);
    #1;
    chk("alarm_gated", 1'h0, aflag);
    for (i = 1; i < 6; i++) begin
      @(posedge clk_in);
      psel <= i[2:0];
      wait_cyc(n);
      wait_cyc(n);
      chk("period", per[i], n);
    end
    @(posedge clk_in);
    lvl <= 1'b1;
    psel <= 3'h1;
    wait_cyc(n);
    repeat (8) @(posedge clk_in);
    #1;
    chk("level_hold", 1'h1, cflag);
    @(posedge clk_in);
    cclr <= 1'b1;
    @(posedge clk_in);
    cclr <= 1'b0;
    #1;
    chk("level_clr", 1'h0, cflag);
    @(posedge clk_in);
    psel <= 3'h0;
    repeat (40) @(posedge clk_in);
    #1;
    chk("cyc_off", 1'h0, cflag);
    @(posedge clk_in);
    en <= 1'b1;
    host.rd(4'h3, q, ok);
    chk("rd_back_ok", 1'h1, ok);
    chk("rd_back", 4'h9, q);
    end_of_test();
  end
endmodule : test_rhp_host_port
